//--- core/bscc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] Off period never shorter than minimum count; after on-time level loss, logic undervoltage or reset the code restarts from idle with no off count.
// [R2] Minimum-level compare low holds both gate requests low.
// [R3] Peak-current compare high ends the high-side on-time.
// [R4] Current limit ends on-time; no new cycle until it clears.
// [R5] Zero-cross compare high turns off the low-side request.
// [R6] A cycle starts with high side on, low side off.
// [R7] On-time end: high side off, low side on, off counter starts.
// [R8] After off-time, start only with level high and limit low.
// [R9] Dropout forces the fixed minimum off period.
// [R10] Default setting gives a nominal 400 kHz switching rate.
// [R11] Report adapter present, power fail and logic undervoltage.
// [R12] Low side waits a dead time after high side turns off.
// [R13] Off length loaded per period from setting; raised to minimum.
// [R14] Logic undervoltage or reset holds gates low, no cycles.
module bscc_core
   import bsccp_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Comparators
   input wire bscc_cmp_s cmp_in,
   input wire bscc_supply_s supply_in,
   input wire logic dropout_in,
   // Off period setting
   input wire logic [OFF_W-1:0] off_period_in,
   // Gate requests
   output logic high_side_gate_out,
   output logic low_side_gate_out,
   // Status
   output bscc_status_s status_out
);

   // Sequencer state
   bscc_state_e state_q;

   // Off period counter, dead time included
   logic [OFF_W-1:0] off_cnt_q;

   // Dead time counter
   logic [3:0] dead_q;

   // Decoded conditions
   logic blocked;
   logic may_start;
   logic end_on;
   logic level_lost;
   logic dead_done;
   logic off_done;
   logic enter_dead;

   // Start condition: level high, limit low
   function automatic logic start_ok(input bscc_cmp_s cmp);
      start_ok = cmp.min_level_compare && !cmp.current_limit_compare; // [R8] [R4]
   endfunction : start_ok

   // On-time end: peak or limit
   function automatic logic on_end(input bscc_cmp_s cmp);
      on_end = cmp.peak_current_compare || cmp.current_limit_compare; // [R3] [R4]
   endfunction : on_end

   // Chosen off length with minimum clamp
   function automatic logic [OFF_W-1:0] off_len(input logic [OFF_W-1:0] req, input logic dropout);
      if (dropout) begin
         off_len = OFF_MIN; // [R9]
      end else if (req < OFF_MIN) begin
         off_len = OFF_MIN; // [R1] [R13]
      end else begin
         off_len = req;
      end
   endfunction : off_len

   // One off count step, held at one
   function automatic logic [OFF_W-1:0] off_step(input logic [OFF_W-1:0] cnt);
      if (cnt > 16'h0001) begin
         off_step = cnt - 16'h0001;
      end else begin
         off_step = cnt;
      end
   endfunction : off_step

   // High-side request for a state
   function automatic logic high_req(input bscc_state_e st, input bscc_cmp_s cmp);
      if (st != BSCC_ON) begin
         high_req = 1'b0; // [R7]
      end else if (!cmp.min_level_compare) begin
         high_req = 1'b0; // [R2]
      end else if (on_end(cmp)) begin
         high_req = 1'b0; // [R3] [R4]
      end else begin
         high_req = 1'b1; // [R6]
      end
   endfunction : high_req

   // Low-side request for a state
   function automatic logic low_req(input bscc_state_e st, input bscc_cmp_s cmp);
      if (st != BSCC_OFF && st != BSCC_WAIT) begin
         low_req = 1'b0; // [R6] [R12]
      end else if (!cmp.min_level_compare) begin
         low_req = 1'b0; // [R2]
      end else if (cmp.zero_cross_compare) begin
         low_req = 1'b0; // [R5]
      end else begin
         low_req = 1'b1; // [R7]
      end
   endfunction : low_req

   assign blocked = supply_in.logic_supply_low; // [R14]
   assign may_start = start_ok(cmp_in);
   assign end_on = on_end(cmp_in);
   assign level_lost = !cmp_in.min_level_compare; // [R2]
   assign dead_done = (dead_q <= 4'h1); // [R12]
   assign off_done = (off_cnt_q <= 16'h0001); // [R1]
   assign enter_dead = (state_q == BSCC_ON) && !level_lost && end_on; // [R7]

   // Sequencer
   always_ff @(posedge clk_in) begin
      if (reset_in || blocked) begin
         state_q <= BSCC_IDLE; // [R14]
      end else begin
         case (state_q)
            BSCC_IDLE: begin
               if (may_start) begin
                  state_q <= BSCC_ON; // [R6] [R8]
               end
            end
            BSCC_ON: begin
               if (level_lost) begin
                  state_q <= BSCC_IDLE; // [R2]
               end else if (end_on) begin
                  state_q <= BSCC_DEAD; // [R3] [R4] [R7]
               end
            end
            BSCC_DEAD: begin
               if (dead_done) begin
                  state_q <= BSCC_OFF; // [R12]
               end
            end
            BSCC_OFF: begin
               if (off_done) begin
                  state_q <= BSCC_WAIT; // [R1]
               end
            end
            BSCC_WAIT: begin
               if (may_start) begin
                  state_q <= BSCC_ON; // [R8] [R4]
               end
            end
            default: begin
               state_q <= BSCC_IDLE;
            end
         endcase
      end
   end

   // Off period count, loaded as the on-time ends
   always_ff @(posedge clk_in) begin
      if (reset_in || blocked) begin
         off_cnt_q <= '0;
      end else if (enter_dead) begin
         off_cnt_q <= off_len(off_period_in, dropout_in); // [R7] [R10] [R13]
      end else if (state_q == BSCC_DEAD || state_q == BSCC_OFF) begin
         off_cnt_q <= off_step(off_cnt_q); // [R1]
      end
   end

   // Dead time count
   always_ff @(posedge clk_in) begin
      if (reset_in || blocked) begin
         dead_q <= '0;
      end else if (enter_dead) begin
         dead_q <= DEAD_CNT; // [R12]
      end else if (state_q == BSCC_DEAD && !dead_done) begin
         dead_q <= dead_q - 4'h1; // [R12]
      end
   end

   // High-side gate request, registered
   always_ff @(posedge clk_in) begin
      if (reset_in || blocked) begin
         high_side_gate_out <= 1'b0; // [R14]
      end else begin
         high_side_gate_out <= high_req(state_q, cmp_in); // [R2] [R3] [R4] [R6]
      end
   end

   // Low-side gate request, registered
   always_ff @(posedge clk_in) begin
      if (reset_in || blocked) begin
         low_side_gate_out <= 1'b0; // [R14]
      end else begin
         low_side_gate_out <= low_req(state_q, cmp_in); // [R2] [R5] [R7]
      end
   end

   // Supply state report
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         status_out <= '0;
      end else begin
         status_out.adapter_present <= supply_in.adapter_above_thresh; // [R11]
         status_out.power_fail <= supply_in.input_below_batt_margin; // [R11]
         status_out.logic_undervoltage <= supply_in.logic_supply_low; // [R11]
      end
   end

endmodule : bscc_core
`default_nettype wire

//--- inc/bsccp_pkg.sv
`default_nettype none
package bsccp_pkg;
   localparam int CLK_PERIOD_PS = 10000;
   // Minimum off period
   localparam int MIN_OFF_NS = 300;
   localparam int MIN_OFF_CYCLES = (MIN_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Dead time between gates
   localparam int DEAD_TIME_NS = 50;
   localparam int DEAD_TIME_CYCLES = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Nominal switching rate with default setting
   localparam int NOMINAL_FREQ_KHZ = 400;
   localparam int NOMINAL_PERIOD_CYCLES = 1000000000 / (NOMINAL_FREQ_KHZ * CLK_PERIOD_PS);
   localparam int OFF_W = 16;
   localparam logic [OFF_W-1:0] OFF_MIN = OFF_W'(MIN_OFF_CYCLES);
   localparam logic [OFF_W-1:0] OFF_DEFAULT = OFF_W'(NOMINAL_PERIOD_CYCLES / 2);
   localparam logic [3:0] DEAD_CNT = 4'(DEAD_TIME_CYCLES);

   typedef enum logic [2:0] {
      BSCC_IDLE = 3'b000,
      BSCC_ON = 3'b001,
      BSCC_DEAD = 3'b010,
      BSCC_OFF = 3'b011,
      BSCC_WAIT = 3'b100
   } bscc_state_e;

   typedef struct packed {
      logic min_level_compare;
      logic peak_current_compare;
      logic current_limit_compare;
      logic zero_cross_compare;
   } bscc_cmp_s;

   typedef struct packed {
      logic adapter_above_thresh;
      logic input_below_batt_margin;
      logic logic_supply_low;
   } bscc_supply_s;

   typedef struct packed {
      logic adapter_present;
      logic power_fail;
      logic logic_undervoltage;
   } bscc_status_s;
endpackage : bsccp_pkg
`default_nettype wire

//--- verification/bscc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bscc_core_sva
   import bsccp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire bscc_cmp_s cmp_in,
   input wire bscc_supply_s supply_in,
   input wire logic high_side_gate_out,
   input wire logic low_side_gate_out,
   input wire bscc_status_s status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] low_q;
   always_ff @(posedge clk_in) begin
      if (reset_in) low_q <= 8'hFF;
      else if (high_side_gate_out) low_q <= 8'h00;
      else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
   end
   a_min_level_off: assert property (!cmp_in.min_level_compare |=> !high_side_gate_out && !low_side_gate_out)
      else $error("gate on at low level");
   a_peak_ends_on: assert property (cmp_in.peak_current_compare |=> !high_side_gate_out)
      else $error("on-time not ended");
   a_limit_ends_on: assert property (cmp_in.current_limit_compare |=> !high_side_gate_out)
      else $error("limit ignored");
   a_zero_cross_lo: assert property (cmp_in.zero_cross_compare |=> !low_side_gate_out)
      else $error("low side on at zero cross");
   a_start_cycle: assert property ($rose(high_side_gate_out) |-> !low_side_gate_out
      && $past(cmp_in.min_level_compare) && !$past(cmp_in.current_limit_compare))
      else $error("bad cycle start");
   a_dead_gap: assert property ($fell(high_side_gate_out) |-> !low_side_gate_out [*5])
      else $error("dead time short");
   a_min_off: assert property ($rose(high_side_gate_out) |-> {8'h00, low_q} >= OFF_MIN)
      else $error("off period short");
   a_undervolt_hold: assert property (supply_in.logic_supply_low |=> !high_side_gate_out && !low_side_gate_out)
      else $error("gate on in undervoltage");
   a_status_copy: assert property (!$past(reset_in) |-> status_out == $past(supply_in))
      else $error("status mismatch");
endmodule : bscc_core_sva
bind bscc_core bscc_core_sva chk_i (.*);
`default_nettype wire

//--- verification/bscc_gate_drv.sv
`timescale 1ns/1ps
`default_nettype none
module bscc_gate_drv #(parameter int ON_LEN = 4) (
   input wire logic clk_in,
   input wire logic hs_in,
   output logic peak_out
);
   int n;
   // Current ramps while the high side conducts
   always_ff @(posedge clk_in) n <= hs_in ? n + 1 : 0;
   assign peak_out = n >= ON_LEN;
endmodule : bscc_gate_drv
`default_nettype wire

//--- verification/tb_bscc_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bscc_core;
   import bsccp_pkg::*;
   typedef struct packed {logic [2:0] c; logic d; logic [15:0] o; logic h; logic l; logic [15:0] g;} bscc_row_s;
   logic clk_in = 0, reset_in = 1, dro = 0, hi, lo, pk;
   logic [2:0] c3 = 3'h0;
   logic [15:0] off = 16'h0000;
   bscc_supply_s sup = 3'h0;
   bscc_status_s st;
   bscc_cmp_s cmp;
   int errors = 0, num_checks = 0, nh, nl, run, gap, cyc;
   bscc_row_s rows[7] = '{
      '{3'h4, 1'b0, 16'h000A, 1'b1, 1'b1, OFF_MIN},
      '{3'h4, 1'b0, 16'h003C, 1'b1, 1'b1, 16'h003C},
      '{3'h4, 1'b1, 16'h003C, 1'b1, 1'b1, OFF_MIN},
      '{3'h4, 1'b0, OFF_DEFAULT, 1'b1, 1'b1, OFF_DEFAULT},
      '{3'h5, 1'b0, 16'h003C, 1'b1, 1'b0, 16'h003C},
      '{3'h6, 1'b0, 16'h003C, 1'b0, 1'b1, 16'h0000},
      '{3'h0, 1'b0, 16'h003C, 1'b0, 1'b0, 16'h0000}};
   assign cmp = {c3[2], pk, c3[1], c3[0]};
   bscc_core dut (.clk_in(clk_in), .reset_in(reset_in), .cmp_in(cmp), .supply_in(sup), .dropout_in(dro),
      .off_period_in(off), .high_side_gate_out(hi), .low_side_gate_out(lo), .status_out(st));
   bscc_gate_drv drv (.clk_in(clk_in), .hs_in(hi), .peak_out(pk));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      nh += hi;
      nl += lo;
      if (hi) begin
         if (run > 0) gap = run;
         run = 0;
      end else run++;
      if (++cyc > 9000) begin
         errors++;
         finish_test();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s exp %0h got %0h", n, e, s);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (4) @(posedge clk_in);
      #1 chk("reset gates", 16'h0000, {hi, lo, st});
      $display("reset test done");
      @(posedge clk_in) reset_in <= 0;
      foreach (rows[i]) begin
         c3 <= rows[i].c;
         dro <= rows[i].d;
         off <= rows[i].o;
         repeat (3) @(posedge clk_in);
         {nh, nl} = 0;
         repeat (500) @(posedge clk_in);
         chk("high seen", rows[i].h, nh != 0);
         chk("low seen", rows[i].l, nl != 0);
         if (rows[i].h) chk("gap", 1, gap >= rows[i].g && gap <= rows[i].g + 4);
         $display("row %0d done", i);
      end
      c3 <= 3'h4;
      sup <= 3'h6;
      repeat (3) @(posedge clk_in);
      chk("status", 16'h0006, st);
      sup <= 3'h1;
      repeat (3) @(posedge clk_in);
      {nh, nl} = 0;
      repeat (200) @(posedge clk_in);
      chk("undervoltage", 16'h0001, {nh != 0, nl != 0, st});
      $display("supply test done");
      finish_test();
   end
endmodule : tb_bscc_core
`default_nettype wire
